// >>> acdsp_pkg.sv
// package of constants for the sample-clock divider, sync and power control
// assumes one clock (sys_clk, 40 MHz) and register access by offset strobes
package acdsp_pkg;
  // register offsets
  localparam logic [7:0] DIV_SYNC_OFFSET = 8'h3A;
  localparam logic [7:0] CLK_DIV_OFFSET = 8'h0B;
  localparam logic [7:0] DCS_CTRL_OFFSET = 8'h09;
  localparam logic [7:0] POWER_OFFSET = 8'h08;
  // field positions of the divider sync register
  localparam int SYNC_EN_BIT = 1;
  localparam int SYNC_ONCE_BIT = 2;
  localparam int SYNC_DONE_BIT = 3;
  // power register field
  localparam int PWR_LSB = 0;
  // reset values
  localparam logic [7:0] DIV_SYNC_RESET = 8'h00;
  localparam logic [2:0] CLK_DIV_RESET = 3'h0;
  localparam logic DCS_RESET = 1'b1;
  localparam logic [1:0] PWR_RESET = 2'h0;
  // power mode encodings
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_FULL_DOWN = 2'h1;
  localparam logic [1:0] PWR_STANDBY = 2'h2;
  // stabiliser relock wait, least and longest
  localparam int CLK_MHZ = 40;
  localparam int RELOCK_MIN_NS = 1500;
  localparam int RELOCK_MAX_NS = 5000;
  localparam int RELOCK_MIN_CYC = (RELOCK_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int RELOCK_MAX_CYC = (RELOCK_MAX_NS * CLK_MHZ) / 1000;
  localparam int RELOCK_W = 8;
  // divider ratio limit
  localparam int DIV_W = 3;
  typedef enum logic [1:0] {ACDSP_RUN, ACDSP_SLEEP, ACDSP_STBY} acdsp_pwr_type;
endpackage

// >>> acdsp_sync2.sv
// two-flop synchroniser for a level arriving from a pin
// assumes the reset given is already the synchronised copy
`timescale 1ns/100ps
module acdsp_sync2 (
  input wire logic sys_clk, // sample clock
  input wire logic rst_n, // active low reset
  input wire logic async_in, // level from outside
  output logic sync_out // level retimed twice
);
  typedef struct packed {
    logic first;
    logic second;
  } acdsp_sync_type;
  acdsp_sync_type st, next_st;
  // first flop feeds only the second
  always_comb begin
    next_st = st;
    next_st.first = async_in;
    next_st.second = st.first;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign sync_out = st.second;
endmodule // acdsp_sync2

// >>> acdsp_relock.sv
// stabiliser lock tracker: restarts its count on a frequency change
// assumes freq_change is a one-cycle pulse on sys_clk
`timescale 1ns/100ps
module acdsp_relock (
  input wire logic sys_clk, // sample clock
  input wire logic rst_n, // active low reset
  input wire logic freq_change, // pulse, clock rate moved
  output logic locked // stabiliser loop locked
);
  typedef struct packed {
    logic [acdsp_pkg::RELOCK_W-1:0] count;
    logic locked;
  } acdsp_lock_type;
  acdsp_lock_type st, next_st;
  localparam logic [acdsp_pkg::RELOCK_W-1:0] LOCK_AT =
    acdsp_pkg::RELOCK_W'(acdsp_pkg::RELOCK_MIN_CYC);
  // count from the change; lock after the least wait, well before the longest
  always_comb begin
    next_st = st;
    if (freq_change) begin
      next_st.count = '0;
      next_st.locked = 1'b0;
    end else if (!st.locked) begin
      next_st.count = st.count + 1'b1;
      if (st.count == LOCK_AT - 1'b1) begin
        next_st.locked = 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign locked = st.locked;
endmodule // acdsp_relock

// >>> acdsp_top.sv
// sample-clock divider with sync reset, duty-cycle stabiliser control
// and power-down / standby control
// assumes register writes arrive as offset + data + strobe on sys_clk,
// and sync, power-down pin and rate-change indication come from pins
//
// Overview of operation
// - The sample clock is divided by a programmable ratio from 1 to 8.
// - Any ratio other than 1 forces the stabiliser on whatever its bit.
// - Sync register bits 1 and 2 pick resync on every pulse or once.
// - A qualifying sync pulse returns the divider to its initial state.
// - The sync input passes a two-flop synchroniser before use.
// - The active stabiliser makes the falling edge mid-period.
// - The stabiliser needs 1.5 to 5 us to relock after a rate change.
// - While unlocked the stabiliser is bypassed.
// - Power-down is requested by register or by the pin driven high.
// - In power-down the output drivers are released to high impedance.
// - Pin low returns to the mode held in the power register.
// - Power-down stops reference, buffer, bias, clock and outputs.
// - Standby, by register only, keeps reference and outputs running.
`timescale 1ns/100ps
module acdsp_top (
  input wire logic sys_clk, // input sample clock
  input wire logic nrst, // async reset, active low
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [7:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data
  input wire logic sync_pin, // external sync input
  input wire logic power_down_request, // power-down pin, high to sleep
  input wire logic rate_change, // pin, clock rate moved
  output logic div_clk_en, // divided sample enable pulse
  output logic div_phase_hi, // divided clock high phase
  output logic dcs_active, // stabiliser retiming falling edge
  output logic ref_on, // reference powered
  output logic ref_buf_on, // reference buffer powered
  output logic bias_on, // bias networks powered
  output logic clk_on, // internal clock running
  output logic data_out_on, // serial data outputs running
  output logic out_drv_oe_n // output driver enable, low drives
);
  typedef struct packed {
    logic rst_a;
    logic rst_b;
    logic [7:0] sync_ctrl;
    logic sync_armed;
    logic [2:0] div_sel;
    logic dcs_en;
    logic [1:0] pwr_mode;
    logic [2:0] div_cnt;
    logic sync_prev;
    logic en;
    logic phase_hi;
    acdsp_pkg::acdsp_pwr_type pwr_state;
    logic [7:0] rdata;
    logic rate_prev;
  } acdsp_top_type;
  acdsp_top_type st, next_st;
  logic rst_n;
  logic sync_s;
  logic rate_s;
  logic pin_pd_s;
  logic dcs_locked;
  logic rate_pulse;
  logic sync_edge;
  logic sync_take;
  logic [2:0] half_cnt;
  // released reset copy for the submodules; drops with nrst at once
  assign rst_n = st.rst_b;
  // pins retimed before any logic looks at them
  acdsp_sync2 u_sync_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(sync_pin),
    .sync_out(sync_s)
  );
  acdsp_sync2 u_pd_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(power_down_request),
    .sync_out(pin_pd_s)
  );
  acdsp_sync2 u_rate_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(rate_change),
    .sync_out(rate_s)
  );
  assign rate_pulse = rate_s & ~st.rate_prev;
  // stabiliser lock timing
  acdsp_relock u_relock (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .freq_change(rate_pulse),
    .locked(dcs_locked)
  );
  // sync qualification: every pulse, or the first after a write
  assign sync_edge = sync_s & ~st.sync_prev;
  assign sync_take = sync_edge & st.sync_ctrl[acdsp_pkg::SYNC_EN_BIT] &
    (~st.sync_ctrl[acdsp_pkg::SYNC_ONCE_BIT] | st.sync_armed);
  // high phase is half the ratio, rounded toward the sampling edge
  assign half_cnt = 3'((4'(st.div_sel) + 4'h1) >> 1);
  always_comb begin
    next_st = st;
    next_st.sync_prev = sync_s;
    next_st.rate_prev = rate_s;
    next_st.en = 1'b0;
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        acdsp_pkg::DIV_SYNC_OFFSET: begin
          next_st.sync_ctrl = reg_wdata;
          next_st.sync_armed = 1'b1; // re-arm one-shot
        end
        acdsp_pkg::CLK_DIV_OFFSET: begin
          next_st.div_sel = reg_wdata[acdsp_pkg::DIV_W-1:0];
        end
        acdsp_pkg::DCS_CTRL_OFFSET: begin
          next_st.dcs_en = reg_wdata[0];
        end
        acdsp_pkg::POWER_OFFSET: begin
          next_st.pwr_mode = reg_wdata[acdsp_pkg::PWR_LSB +: 2];
        end
        default: begin
        end
      endcase
    end
    // one-shot consumed by the pulse it used; a same-cycle write re-arms
    if (sync_take && st.sync_ctrl[acdsp_pkg::SYNC_ONCE_BIT] &&
        !(reg_wr && reg_addr == acdsp_pkg::DIV_SYNC_OFFSET)) begin
      next_st.sync_armed = 1'b0;
    end
    // divider: count 0..div_sel, sample enable when the count wraps
    if (sync_take) begin
      next_st.div_cnt = 3'h0;
      next_st.phase_hi = 1'b0;
    end else if (st.pwr_state != acdsp_pkg::ACDSP_SLEEP) begin
      if (st.div_cnt >= st.div_sel) begin
        next_st.div_cnt = 3'h0;
        next_st.en = 1'b1;
        next_st.phase_hi = 1'b1;
      end else begin
        next_st.div_cnt = st.div_cnt + 3'h1;
        if (st.div_cnt + 3'h1 >= half_cnt && st.div_sel != 3'h0) begin
          next_st.phase_hi = 1'b0;
        end
      end
      if (st.div_sel == 3'h0) begin
        next_st.phase_hi = 1'b1; // ratio 1 follows raw clock
      end
    end
    // power state: pin or register full power-down wins over standby
    if (pin_pd_s || st.pwr_mode == acdsp_pkg::PWR_FULL_DOWN) begin
      next_st.pwr_state = acdsp_pkg::ACDSP_SLEEP;
    end else if (st.pwr_mode == acdsp_pkg::PWR_STANDBY) begin
      next_st.pwr_state = acdsp_pkg::ACDSP_STBY;
    end else begin
      next_st.pwr_state = acdsp_pkg::ACDSP_RUN;
    end
    // register read data
    if (reg_rd) begin
      case (reg_addr)
        acdsp_pkg::DIV_SYNC_OFFSET: begin
          next_st.rdata = st.sync_ctrl;
          // done flag only means something in one-shot mode
          next_st.rdata[acdsp_pkg::SYNC_DONE_BIT] =
            st.sync_ctrl[acdsp_pkg::SYNC_ONCE_BIT] & ~st.sync_armed;
        end
        acdsp_pkg::CLK_DIV_OFFSET: next_st.rdata = {5'h00, st.div_sel};
        acdsp_pkg::DCS_CTRL_OFFSET: next_st.rdata = {6'h00, dcs_locked,
          st.dcs_en};
        acdsp_pkg::POWER_OFFSET: next_st.rdata = {6'h00, st.pwr_mode};
        default: next_st.rdata = 8'h00;
      endcase
    end
    // reset release through two flops; everything else is held at its
    // reset value until the second one is high, so all leaves together
    next_st.rst_a = 1'b1;
    next_st.rst_b = st.rst_a;
    if (!st.rst_b) begin
      next_st.sync_ctrl = acdsp_pkg::DIV_SYNC_RESET;
      next_st.sync_armed = 1'b0;
      next_st.div_sel = acdsp_pkg::CLK_DIV_RESET;
      next_st.dcs_en = acdsp_pkg::DCS_RESET;
      next_st.pwr_mode = acdsp_pkg::PWR_RESET;
      next_st.div_cnt = 3'h0;
      next_st.sync_prev = 1'b0;
      next_st.en = 1'b0;
      next_st.phase_hi = 1'b0;
      next_st.pwr_state = acdsp_pkg::ACDSP_RUN;
      next_st.rdata = 8'h00;
      next_st.rate_prev = 1'b0;
    end
  end
  // single state register; nrst clears it at once, release is delayed
  // by the hold above rather than by a second reset net
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st.rst_a <= 1'b0;
      st.rst_b <= 1'b0;
      st.sync_ctrl <= acdsp_pkg::DIV_SYNC_RESET;
      st.sync_armed <= 1'b0;
      st.div_sel <= acdsp_pkg::CLK_DIV_RESET;
      st.dcs_en <= acdsp_pkg::DCS_RESET;
      st.pwr_mode <= acdsp_pkg::PWR_RESET;
      st.div_cnt <= 3'h0;
      st.sync_prev <= 1'b0;
      st.en <= 1'b0;
      st.phase_hi <= 1'b0;
      st.pwr_state <= acdsp_pkg::ACDSP_RUN;
      st.rdata <= 8'h00;
      st.rate_prev <= 1'b0;
    end else begin
      st <= next_st;
    end
  end
  // outputs
  assign reg_rdata = st.rdata;
  assign div_clk_en = st.en;
  assign div_phase_hi = st.phase_hi;
  // forced on for ratios above 1, bypassed while relocking
  assign dcs_active = (st.dcs_en || st.div_sel != 3'h0) &&
    dcs_locked;
  // standby keeps reference and data outputs; sleep drops everything
  always_comb begin
    ref_on = 1'b1;
    ref_buf_on = 1'b1;
    bias_on = 1'b1;
    clk_on = 1'b1;
    data_out_on = 1'b1;
    out_drv_oe_n = 1'b0;
    case (st.pwr_state)
      acdsp_pkg::ACDSP_SLEEP: begin
        ref_on = 1'b0;
        ref_buf_on = 1'b0;
        bias_on = 1'b0;
        clk_on = 1'b0;
        data_out_on = 1'b0;
        out_drv_oe_n = 1'b1;
      end
      acdsp_pkg::ACDSP_STBY: begin
        ref_buf_on = 1'b0;
        bias_on = 1'b0;
      end
      default: begin
      end
    endcase
  end
endmodule // acdsp_top

// >>> acdsp_properties.sv
// checker for divider timing, stabiliser state and power outputs
// assumes register writes are one-cycle strobes on sys_clk
`timescale 1ns/100ps
module acdsp_properties (
  input wire logic sys_clk, // sample clock
  input wire logic nrst, // reset, active low
  input wire logic reg_wr, // write strobe
  input wire logic [7:0] reg_addr, // offset
  input wire logic [7:0] reg_wdata, // write data
  input wire logic sync_pin, // sync input
  input wire logic power_down_request, // power-down pin
  input wire logic rate_change, // rate pin
  input wire logic div_clk_en, // divided pulse
  input wire logic dcs_active, // stabiliser on
  input wire logic ref_on, // reference
  input wire logic ref_buf_on, // reference buffer
  input wire logic bias_on, // bias
  input wire logic clk_on, // internal clock
  input wire logic data_out_on, // data outputs
  input wire logic out_drv_oe_n // driver enable
);
  logic [7:0] lk, qt, gp, sc;
  logic [1:0] sq;
  logic [2:0] dq;
  logic wr_div;
  logic wr_pwr;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  assign wr_div = reg_wr && reg_addr == acdsp_pkg::CLK_DIV_OFFSET;
  assign wr_pwr = reg_wr && reg_addr == acdsp_pkg::POWER_OFFSET;
  // shadows and counts since each disturbance, saturating
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lk <= 8'h00;
      qt <= 8'h00;
      gp <= 8'h00;
      sc <= 8'hFF;
      sq <= 2'h0;
      dq <= 3'h0;
    end else begin
      lk <= $rose(rate_change) ? 8'h00 : lk + 8'(lk != 8'hFF);
      qt <= (wr_div || $rose(sync_pin) || !clk_on) ? 8'h00 :
        qt + 8'(qt != 8'hFF);
      gp <= div_clk_en ? 8'h00 : gp + 8'(gp != 8'hFF);
      sc <= $rose(sync_pin) ? 8'h01 : sc + 8'(sc != 8'hFF);
      if (wr_div) begin
        dq <= reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == acdsp_pkg::DIV_SYNC_OFFSET) begin
        sq <= reg_wdata[2:1];
      end
    end
  end
  sequence pin_held;
    power_down_request [*7];
  endsequence
  // every-pulse mode, between sync pickup and first realigned pulse
  sequence sync_window;
    sq == 2'h1 && sc > 8'h04 && sc <= 8'(dq) + 8'h04;
  endsequence
  // register power-down request; state follows two edges on
  sequence reg_sleep;
    wr_pwr && reg_wdata[1:0] == acdsp_pkg::PWR_FULL_DOWN;
  endsequence
  // standby asked with the pin quiet, so the pin cannot win meanwhile
  sequence quiet_standby;
    !power_down_request ##1
      (wr_pwr && reg_wdata[1:0] == acdsp_pkg::PWR_STANDBY);
  endsequence
  a_pin_down: assert property (
    pin_held |-> out_drv_oe_n && !clk_on)
    else $error("pin power-down not taken");
  a_reg_sleep: assert property (
    reg_sleep |-> ##2 (out_drv_oe_n && !ref_on && !data_out_on))
    else $error("register power-down not taken");
  a_reg_standby: assert property (
    quiet_standby |-> ##2 (ref_on && !ref_buf_on && clk_on && data_out_on))
    else $error("register standby not taken");
  a_off_all: assert property (out_drv_oe_n |->
    !(ref_on || ref_buf_on || bias_on || clk_on || data_out_on))
    else $error("power-down left a supply on");
  a_standby_keeps: assert property (ref_on && !bias_on |->
    clk_on && data_out_on && !out_drv_oe_n)
    else $error("standby stopped outputs");
  a_rate_drop: assert property (
    $rose(rate_change) |-> ##[1:6] !dcs_active)
    else $error("stabiliser not bypassed");
  a_relock_min: assert property (
    lk >= 8'h06 && lk < 8'(acdsp_pkg::RELOCK_MIN_CYC) |-> !dcs_active)
    else $error("stabiliser relocked early");
  a_dcs_forced: assert property (
    dq != 3'h0 && lk > 8'hD2 |-> dcs_active)
    else $error("stabiliser not forced");
  a_div_period: assert property (
    div_clk_en && qt > 8'h14 |-> gp == 8'(dq))
    else $error("divided period wrong");
  a_sync_align: assert property (sync_window |->
    div_clk_en == (sc == 8'(dq) + 8'd4))
    else $error("divider not realigned by sync");
endmodule // acdsp_properties

// >>> acdsp_clk_partner.sv
// far-side model driving the sync and rate-change pins
// assumes calls come just after a rising sys_clk edge
`timescale 1ns/100ps
module acdsp_clk_partner (
  input wire logic sys_clk, // sample clock
  output logic sync_pin, // sync level
  output logic rate_change // clock rate moved
);
  initial sync_pin = 1'b0;
  initial rate_change = 1'b0;
  // level set in step with the shared clock, so all parts agree
  task automatic drive_sync(input logic v);
    sync_pin = v;
  endtask
  // rate flag held four cycles so the synchroniser cannot miss it
  task automatic rate_step;
    rate_change = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    rate_change = 1'b0;
  endtask
endmodule // acdsp_clk_partner

// >>> test_adc_clock_divider_sync_power.sv
// bench for the divider, sync, stabiliser and power control
// assumes the partner model drives sync and rate pins
`timescale 1ns/100ps
module test_adc_clock_divider_sync_power;
  localparam logic [7:0] SYNC_A = acdsp_pkg::DIV_SYNC_OFFSET;
  localparam logic [7:0] DIV_A = acdsp_pkg::CLK_DIV_OFFSET;
  localparam logic [7:0] DCS_A = acdsp_pkg::DCS_CTRL_OFFSET;
  localparam logic [7:0] PWR_A = acdsp_pkg::POWER_OFFSET;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic power_down_request = 1'b0;
  logic [7:0] reg_rdata;
  logic sync_pin, rate_change, div_clk_en, div_phase_hi, dcs_active;
  logic ref_on, ref_buf_on, bias_on, clk_on, data_out_on, out_drv_oe_n;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int checks_done = 0;
  int n;
  int hi;
  always #12.5 sys_clk = ~sys_clk;
  acdsp_top uut (.sys_clk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .sync_pin, .power_down_request, .rate_change, .div_clk_en,
    .div_phase_hi, .dcs_active, .ref_on, .ref_buf_on, .bias_on, .clk_on,
    .data_out_on, .out_drv_oe_n);
  acdsp_clk_partner far_end (.sys_clk, .sync_pin, .rate_change);
  task automatic chk(input string what, input logic [7:0] e,
    input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    cyc(1);
  endtask
  // edges until the next divided pulse, bounded; high phase counted too
  task automatic wait_en;
    n = 0;
    hi = 0;
    do begin
      cyc(1);
      n++;
      if (div_phase_hi === 1'b1) hi++;
    end while (div_clk_en !== 1'b1 && n < 40);
  endtask
  // sync raised right after a pulse; realigned or old phase tells apart
  task automatic sync_meas(input int e);
    cyc($urandom_range(1, 6));
    wait_en();
    far_end.drive_sync(1'b1);
    wait_en();
    chk("sync delay", 8'(e), 8'(n));
    far_end.drive_sync(1'b0);
  endtask
  task automatic pwr(input logic [5:0] e);
    chk("power", {2'b00, e}, {2'b00, ref_on, ref_buf_on, bias_on, clk_on,
      data_out_on, out_drv_oe_n});
  endtask
  // read data compared one cycle after the strobe edge
  always @(posedge sys_clk) begin
    if (rd_seen) chk("rdata", exp_q.pop_front(), reg_rdata);
    rd_seen <= reg_rd;
  end
  initial begin
    #(25 * 6000);
    n_fail++;
    print_verdict();
  end
  initial begin
    void'($urandom(56));
    cyc(4);
    nrst = 1'b1;
    cyc(3);
    rd(SYNC_A, acdsp_pkg::DIV_SYNC_RESET);
    rd(DIV_A, 8'h00);
    rd(PWR_A, 8'h00);
    rd(DCS_A, 8'h01);
    wr(8'h55, 8'($urandom));
    rd(8'h55, 8'h00);
    wr(DCS_A, 8'h00);
    cyc(200);
    for (int s = 0; s < 8; s++) begin
      wr(DIV_A, 8'(s));
      wait_en();
      wait_en();
      chk("period", 8'(s + 1), 8'(n));
      chk("high time", 8'(s == 0 ? 1 : (s + 1) / 2), 8'(hi));
      chk("forced", 8'(s != 0), 8'(dcs_active));
      rd(DIV_A, 8'(s));
    end
    rd(DCS_A, 8'h02);
    far_end.rate_step();
    cyc(20);
    chk("unlocked", 8'h00, 8'(dcs_active));
    rd(DCS_A, 8'h00);
    cyc(200);
    chk("relocked", 8'h01, 8'(dcs_active));
    wr(DIV_A, 8'h03);
    wr(SYNC_A, 8'h02);
    sync_meas(7);
    sync_meas(7);
    wr(SYNC_A, 8'h06);
    rd(SYNC_A, 8'h06);
    sync_meas(7);
    rd(SYNC_A, 8'h0E);
    sync_meas(4);
    wr(SYNC_A, 8'h00);
    sync_meas(4);
    wr(DIV_A, 8'h00);
    power_down_request = 1'b1;
    cyc(8);
    pwr(6'h01);
    power_down_request = 1'b0;
    cyc(4);
    pwr(6'h3E);
    wr(PWR_A, 8'h01);
    cyc(2);
    pwr(6'h01);
    wr(PWR_A, 8'h02);
    cyc(2);
    pwr(6'h26);
    rd(PWR_A, 8'h02);
    wr(PWR_A, 8'h00);
    cyc(2);
    pwr(6'h3E);
    print_verdict();
  end
endmodule // test_adc_clock_divider_sync_power
bind acdsp_top acdsp_properties chk_props (.sys_clk, .nrst, .reg_wr,
  .reg_addr, .reg_wdata, .sync_pin, .power_down_request, .rate_change,
  .div_clk_en, .dcs_active, .ref_on, .ref_buf_on, .bias_on, .clk_on,
  .data_out_on, .out_drv_oe_n);
